/* File: pts_pkg.sv */
// package: constants and types for the positioning transition sequencer
package pts_pkg;

   // -----------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // -----------------------------------------------------------------
   localparam logic [7:0]  PTS_OFS_STATUS   = 8'h00;
   localparam logic [7:0]  PTS_OFS_SETTINGS = 8'h04;
   localparam logic [7:0]  PTS_OFS_ZONE     = 8'h08;

   // status register fields
   localparam int          PTS_ST_MODE_LSB  = 0;
   localparam int          PTS_ST_WAIT_BIT  = 2;
   localparam int          PTS_ST_PREV_BIT  = 3;
   localparam int          PTS_ST_AXES_LSB  = 4;
   // settings register fields
   localparam int          PTS_SET_DECEL    = 0;
   localparam int          PTS_SET_CONSTACC = 1;
   // in-position zone reset value (pulses)
   localparam logic [15:0] PTS_ZONE_RST     = 16'h000a;

   // -----------------------------------------------------------------
   // block kinds from the command source
   // -----------------------------------------------------------------
   localparam logic [3:0]  PTS_K_LINEAR     = 4'h0;
   localparam logic [3:0]  PTS_K_CIRCULAR   = 4'h1;
   localparam logic [3:0]  PTS_K_TRAVERSE   = 4'h2;
   localparam logic [3:0]  PTS_K_PTP        = 4'h3;  // point_to_point_move
   localparam logic [3:0]  PTS_K_ORIGIN     = 4'h4;  // origin search / returns
   localparam logic [3:0]  PTS_K_OTHER      = 4'h5;  // stop-only motion
   localparam logic [3:0]  PTS_K_SET_PASS   = 4'h8;
   localparam logic [3:0]  PTS_K_SET_STOP   = 4'h9;
   localparam logic [3:0]  PTS_K_SET_NOCHK  = 4'ha;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int          PTS_CLK_MHZ      = 250;
   localparam int          PTS_NOCHK_US     = 4000;  // 4 ms
   localparam int          PTS_NOCHK_CYC    = PTS_NOCHK_US * PTS_CLK_MHZ;

   // operating modes and sequencer states
   typedef enum logic [1:0] {PTS_M_PASS, PTS_M_STOP, PTS_M_NOCHK} pts_mode_t;
   typedef enum logic [1:0] {
      PTS_S_READY, PTS_S_WAIT_INPOS, PTS_S_WAIT_GEN, PTS_S_WAIT_NOCHK
   } pts_state_t;

endpackage

/* File: pts_inpos_chk.sv */
// in-position judgement for one servo axis
`timescale 1ns/1ps
`default_nettype none
module pts_inpos_chk #(
   parameter int ERR_W = 16
) (
   // axis selection and error feedback
   input  wire logic              axis_used,
   input  wire logic [ERR_W-1:0]  err_cnt,
   input  wire logic [15:0]       zone,
   // result
   output logic                   in_zone
);
   logic [ERR_W:0] mag;

   // magnitude one bit wider so the most negative count does not wrap
   always_comb begin
      if (err_cnt[ERR_W-1]) begin
         mag = (ERR_W+1)'(-$signed({err_cnt[ERR_W-1], err_cnt}));
      end else begin
         mag = {1'b0, err_cnt};
      end
   end

   // an axis outside the operation never holds completion back
   assign in_zone = !axis_used || (mag <= (ERR_W+1)'(zone));
endmodule
`default_nettype wire

/* File: pts_sequencer.sv */
// top: transition sequencer between consecutive positioning operations
//
// Function
// RULE1 - stop mode starts the next queued operation only after completion
// RULE2 - completion means every axis error count is inside the in-position zone; code checks only the axes of the operation in progress
// RULE3 - with completion check off, next operation starts within 4 ms
// RULE4 - pass mode chains operations without pause and without completion check
// RULE5 - pass mode is active after power-up
// RULE6 - pass timing setting picks acceleration or deceleration overlap
// RULE7 - constant acceleration applies only to single-axis linear moves
// RULE8 - constant acceleration overrides the pass timing choice
// RULE9 - both settings are read-only to the host
// RULE10 - pass transitions use a trapezoidal profile even if S-curve requested
// RULE11 - constant-acceleration passes keep fixed accel and decel times
// RULE12 - with constant acceleration, next linear waits for full demand generation
// RULE13 - completion-check-off command selects start-without-waiting mode
// RULE14 - stop command restores waiting for completion
// RULE15 - multi-axis move after constant-acceleration linear always waits completion
// RULE16 - after linear pass; after circular pass only linear or same-plane circular
// RULE17 - after traverse pass into linear; stop before circular or other-axis traverse
// RULE18 - a changed set of operated axes counts as different axes
// RULE19 - traverse after traverse passes when rotation agrees, else stops
// RULE20 - a mode stays until the next mode-changing command or event
// RULE21 - next operation waits pending, released the cycle after completion
`timescale 1ns/1ps
`default_nettype none
module pts_sequencer
   import pts_pkg::*;
#(
   parameter int AXES      = 4,
   parameter int ERR_W     = 16,
   parameter int NOCHK_CYC = pts_pkg::PTS_NOCHK_CYC
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   // unit settings from the configuration store
   input  wire logic                  cfg_pass_decel,
   input  wire logic                  cfg_const_acc,
   // command source
   input  wire logic                  prog_restart,
   input  wire logic                  blk_valid,
   output logic                       blk_ready,
   input  wire logic [3:0]            blk_kind,
   input  wire logic [AXES-1:0]       blk_axes,
   input  wire logic [1:0]            blk_plane,
   input  wire logic                  blk_dir_same,
   // demand generator
   input  wire logic                  gen_done,
   output logic                       mv_start,
   output logic [3:0]                 mv_kind,
   output logic [AXES-1:0]            mv_axes,
   output logic [1:0]                 mv_plane,
   output logic                       mv_pass,
   output logic                       mv_overlap_decel,
   output logic                       mv_const_acc,
   output logic                       mv_trapezoid,
   // servo error counters, axis 0 in the low bits
   input  wire logic [AXES*ERR_W-1:0] srv_err
);
   import pts_pkg::*;

   localparam logic [19:0] NOCHK_LAST = 20'(NOCHK_CYC - 1);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pts_mode_t       mode_q;
   pts_state_t      state_q;
   logic            loaded_q, set_decel_q, set_ca_q;
   logic [15:0]     zone_q;
   logic            have_prev_q, prev_ca_q;
   logic [3:0]      prev_kind_q;
   logic [AXES-1:0] prev_axes_q;
   logic [1:0]      prev_plane_q;
   logic [19:0]     nochk_cnt_q;
   logic [3:0]      pend_kind_q;
   logic [AXES-1:0] pend_axes_q;
   logic [1:0]      pend_plane_q;
   logic            pend_pass_q, pend_ca_q;

   logic            accept, is_mode_cmd, cur_interp, prev_interp, cur_ca, axes_same;
   logic            tbl_pass, go_now, go_pass, inpos_all, done_ok;
   pts_state_t      wait_sel;
   logic [AXES-1:0] axis_ok;

   assign blk_ready   = (state_q == PTS_S_READY) && !mv_start && rst_n;
   assign accept      = blk_valid && blk_ready;
   assign is_mode_cmd = blk_kind[3];

   // ----------------------------------------------------------------
   // settings captured once after reset release, never written by software
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loaded_q    <= 1'b0;
         set_decel_q <= 1'b0;
         set_ca_q    <= 1'b0;
      end else if (!loaded_q) begin
         loaded_q    <= 1'b1;
         set_decel_q <= cfg_pass_decel;
         set_ca_q    <= cfg_const_acc;     // see RULE9
      end
   end

   // ----------------------------------------------------------------
   // in-position judgement per axis of the operation in progress
   // ----------------------------------------------------------------
   for (genvar i = 0; i < AXES; i++) begin : g_axis
      pts_inpos_chk #(.ERR_W(ERR_W)) u_chk (
         .axis_used (prev_axes_q[i]),
         .err_cnt   (srv_err[i*ERR_W +: ERR_W]),
         .zone      (zone_q),
         .in_zone   (axis_ok[i])
      );
   end
   assign inpos_all = &axis_ok;             // see RULE2
   assign done_ok   = gen_done && inpos_all;

   // ----------------------------------------------------------------
   // transition classification of the offered block against the last one
   // ----------------------------------------------------------------
   assign cur_interp  = (blk_kind == PTS_K_LINEAR) || (blk_kind == PTS_K_CIRCULAR)
                        || (blk_kind == PTS_K_TRAVERSE);
   assign prev_interp = (prev_kind_q == PTS_K_LINEAR) || (prev_kind_q == PTS_K_CIRCULAR)
                        || (prev_kind_q == PTS_K_TRAVERSE);
   assign cur_ca      = set_ca_q && (blk_kind == PTS_K_LINEAR)
                        && ($countones(blk_axes) == 1);          // see RULE7
   assign axes_same   = (blk_axes == prev_axes_q);               // see RULE18

   // pass/stop table for interpolation pairs in pass mode
   always_comb begin
      tbl_pass = 1'b0;
      if (prev_kind_q == PTS_K_LINEAR) begin
         tbl_pass = 1'b1;                                        // see RULE16
      end else if (prev_kind_q == PTS_K_CIRCULAR) begin
         tbl_pass = (blk_kind == PTS_K_LINEAR) ||
                    ((blk_kind == PTS_K_CIRCULAR) && (blk_plane == prev_plane_q));
      end else if (prev_kind_q == PTS_K_TRAVERSE) begin
         tbl_pass = (blk_kind == PTS_K_LINEAR) ||                // see RULE17
                    ((blk_kind == PTS_K_TRAVERSE) && axes_same && blk_dir_same); // see RULE19
      end
   end

   // which wait, if any, the block must sit through before it starts
   always_comb begin
      wait_sel = PTS_S_READY;
      go_pass  = 1'b0;
      if (!have_prev_q) begin
         wait_sel = PTS_S_READY;
      end else if (!cur_interp || !prev_interp || mode_q == PTS_M_STOP) begin
         wait_sel = PTS_S_WAIT_INPOS;                            // see RULE1
      end else if (prev_ca_q && ($countones(blk_axes) > 1)) begin
         wait_sel = PTS_S_WAIT_INPOS;                            // see RULE15
      end else if (mode_q == PTS_M_NOCHK) begin
         wait_sel = PTS_S_WAIT_NOCHK;
      end else if (!tbl_pass) begin
         wait_sel = PTS_S_WAIT_INPOS;
      end else if (prev_ca_q && cur_ca) begin
         wait_sel = PTS_S_WAIT_GEN;                              // see RULE12
         go_pass  = 1'b1;
      end else begin
         go_pass  = 1'b1;                                        // see RULE4
      end
   end
   assign go_now = (wait_sel == PTS_S_READY);

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= PTS_M_PASS;                                   // see RULE5
      end else if (prog_restart) begin
         mode_q <= PTS_M_PASS;                                   // see RULE20
      end else if (accept) begin
         if (blk_kind == PTS_K_SET_PASS || blk_kind == PTS_K_ORIGIN) begin
            mode_q <= PTS_M_PASS;
         end else if (blk_kind == PTS_K_SET_STOP) begin
            mode_q <= PTS_M_STOP;                                // see RULE14
         end else if (blk_kind == PTS_K_SET_NOCHK) begin
            mode_q <= PTS_M_NOCHK;                               // see RULE13
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer: hold the pending block, release it on completion, generator done or time limit
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= PTS_S_READY;
         nochk_cnt_q <= 20'h00000;
      end else begin
         unique case (state_q)
            PTS_S_READY: begin
               nochk_cnt_q <= 20'h00000;
               if (accept && !is_mode_cmd) begin
                  state_q <= wait_sel;
               end
            end
            PTS_S_WAIT_INPOS: begin
               if (done_ok) begin
                  state_q <= PTS_S_READY;                        // see RULE21
               end
            end
            PTS_S_WAIT_GEN: begin
               if (gen_done) begin
                  state_q <= PTS_S_READY;
               end
            end
            PTS_S_WAIT_NOCHK: begin
               nochk_cnt_q <= nochk_cnt_q + 20'h00001;
               // the generator finishing or the time limit, whichever comes first
               if (gen_done || nochk_cnt_q == NOCHK_LAST) begin
                  state_q <= PTS_S_READY;                        // see RULE3
               end
            end
         endcase
      end
   end

   // pending block held while a wait runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_kind_q  <= PTS_K_LINEAR;
         pend_axes_q  <= '0;
         pend_plane_q <= 2'h0;
         pend_pass_q  <= 1'b0;
         pend_ca_q    <= 1'b0;
      end else if (accept && !is_mode_cmd) begin
         pend_kind_q  <= blk_kind;
         pend_axes_q  <= blk_axes;
         pend_plane_q <= blk_plane;
         pend_pass_q  <= go_pass;
         pend_ca_q    <= cur_ca;
      end
   end

   // history of the operation now in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         have_prev_q  <= 1'b0;
         prev_ca_q    <= 1'b0;
         prev_kind_q  <= PTS_K_LINEAR;
         prev_axes_q  <= '0;
         prev_plane_q <= 2'h0;
      end else if (prog_restart) begin
         have_prev_q  <= 1'b0;
      end else if (mv_start) begin
         have_prev_q  <= 1'b1;
         prev_ca_q    <= mv_const_acc;
         prev_kind_q  <= mv_kind;
         prev_axes_q  <= mv_axes;
         prev_plane_q <= mv_plane;
      end
   end

   // ----------------------------------------------------------------
   // start strobe and profile selection to the demand generator
   // ----------------------------------------------------------------
   logic release_now;
   assign release_now = (state_q == PTS_S_WAIT_INPOS && done_ok) ||
                        (state_q == PTS_S_WAIT_GEN && gen_done) ||
                        (state_q == PTS_S_WAIT_NOCHK &&
                         (gen_done || nochk_cnt_q == NOCHK_LAST));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mv_start         <= 1'b0;
         mv_kind          <= PTS_K_LINEAR;
         mv_axes          <= '0;
         mv_plane         <= 2'h0;
         mv_pass          <= 1'b0;
         mv_overlap_decel <= 1'b0;
         mv_const_acc     <= 1'b0;
         mv_trapezoid     <= 1'b0;
      end else if (accept && !is_mode_cmd && go_now) begin
         mv_start         <= 1'b1;
         mv_kind          <= blk_kind;
         mv_axes          <= blk_axes;
         mv_plane         <= blk_plane;
         mv_pass          <= go_pass;
         mv_const_acc     <= cur_ca;
         mv_overlap_decel <= go_pass && set_decel_q && !cur_ca;  // see RULE6, see RULE8
         mv_trapezoid     <= go_pass;                            // see RULE10
      end else if (release_now) begin
         mv_start         <= 1'b1;
         mv_kind          <= pend_kind_q;
         mv_axes          <= pend_axes_q;
         mv_plane         <= pend_plane_q;
         mv_pass          <= pend_pass_q;
         // fixed accel/decel times travel with the constant-acceleration flag
         mv_const_acc     <= pend_ca_q;                          // see RULE11
         mv_overlap_decel <= pend_pass_q && set_decel_q && !pend_ca_q;
         mv_trapezoid     <= pend_pass_q;
      end else begin
         mv_start         <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // apb slave: zero wait states, read data captured in the setup cycle
   // ----------------------------------------------------------------
   logic        addr_hit, addr_ro;
   logic [31:0] rd_val;

   assign addr_hit = (paddr == PTS_OFS_STATUS) || (paddr == PTS_OFS_SETTINGS)
                     || (paddr == PTS_OFS_ZONE);
   assign addr_ro  = (paddr == PTS_OFS_STATUS) || (paddr == PTS_OFS_SETTINGS);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && (!addr_hit || (pwrite && addr_ro));

   always_comb begin
      rd_val = 32'h00000000;
      if (paddr == PTS_OFS_STATUS) begin
         rd_val[PTS_ST_MODE_LSB +: 2]    = mode_q;
         rd_val[PTS_ST_WAIT_BIT]         = (state_q != PTS_S_READY);
         rd_val[PTS_ST_PREV_BIT]         = have_prev_q;
         rd_val[PTS_ST_AXES_LSB +: AXES] = prev_axes_q;
      end else if (paddr == PTS_OFS_SETTINGS) begin
         rd_val[PTS_SET_DECEL]           = set_decel_q;
         rd_val[PTS_SET_CONSTACC]        = set_ca_q;
      end else if (paddr == PTS_OFS_ZONE) begin
         rd_val[15:0]                    = zone_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end

   // only the zone is writable; settings stay as captured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zone_q <= PTS_ZONE_RST;
      end else if (psel && penable && pwrite && paddr == PTS_OFS_ZONE) begin
         zone_q <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_cmd(logic [3:0] k);
      accept && blk_kind == k && !prog_restart;
   endsequence
   sequence s_inpos_done;
      state_q == PTS_S_WAIT_INPOS && done_ok;
   endsequence

   property p_mode_reset;
      $rose(rst_n) |-> mode_q == PTS_M_PASS;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("mode not pass"); // see RULE5

   property p_cmd_stop;
      s_cmd(PTS_K_SET_STOP) |=> mode_q == PTS_M_STOP;
   endproperty
   a_cmd_stop: assert property (p_cmd_stop) else $error("stop cmd ignored"); // see RULE14

   property p_cmd_nochk;
      s_cmd(PTS_K_SET_NOCHK) |=> mode_q == PTS_M_NOCHK;
   endproperty
   a_cmd_nochk: assert property (p_cmd_nochk) else $error("nochk cmd ignored"); // see RULE13

   property p_release;
      s_inpos_done |=> mv_start ##1 !mv_start;
   endproperty
   a_release: assert property (p_release) else $error("late release"); // see RULE21

   property p_inpos_cause;
      mv_start && $past(state_q) == PTS_S_WAIT_INPOS |-> $past(inpos_all) && $past(gen_done);
   endproperty
   a_inpos_cause: assert property (p_inpos_cause) else $error("start before inpos"); // see RULE2

   property p_nochk_bound;
      state_q == PTS_S_WAIT_NOCHK |-> nochk_cnt_q <= NOCHK_LAST;
   endproperty
   a_nochk_bound: assert property (p_nochk_bound) else $error("nochk overrun"); // see RULE3

   property p_pass_now;
      accept && !is_mode_cmd && go_now && go_pass |=> mv_start && mv_pass && mv_trapezoid;
   endproperty
   a_pass_now: assert property (p_pass_now) else $error("pass not immediate"); // see RULE4

   property p_ca_prio;
      mv_start && mv_const_acc |-> !mv_overlap_decel;
   endproperty
   a_ca_prio: assert property (p_ca_prio) else $error("ca ignored"); // see RULE8

   property p_multi_after_ca;
      accept && have_prev_q && prev_ca_q && cur_interp && prev_interp
         && $countones(blk_axes) > 1 |=> state_q == PTS_S_WAIT_INPOS;
   endproperty
   a_multi_after_ca: assert property (p_multi_after_ca) else $error("no wait"); // see RULE15

endmodule
`default_nettype wire

/* File: pts_servo_model.sv */
// behavioural servo drives and demand generator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pts_servo_model (
   // clock and motion start
   input  wire logic        clk,
   input  wire logic        mv_start,
   // knobs: generation length and settling time, in cycles
   input  wire logic [7:0]  gen_len,
   input  wire logic [7:0]  settle,
   // feedback to the sequencer
   output logic             gen_done,
   output logic [63:0]      srv_err
);
   logic [8:0]  cnt_q = 9'h1ff;
   logic [15:0] err;
   // count from each start; saturates so an idle drive stays settled
   always @(posedge clk) begin
      if (mv_start) cnt_q <= 9'h000;
      else if (cnt_q != 9'h1ff) cnt_q <= cnt_q + 9'h001;
   end
   assign gen_done = (cnt_q >= {1'h0, gen_len});
   // lag stays outside any small zone until the drive has settled
   assign err = (cnt_q >= {1'h0, gen_len} + {1'h0, settle}) ? 16'h0000 : 16'h0032;
   assign srv_err = {4{err}};
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the transition sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pts_pkg::*;
   logic        clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00, gl = 8'h08, st = 8'h10;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, perr, rdy, vld = 1'h0, rst_p = 1'h0, dsame = 1'h0;
   logic        gdone, mvs, mvp, ovd, mtr, mca, ca = 1'h0;
   logic [3:0]  mk, mva;
   logic [1:0]  mpl;
   logic [3:0]  kind = 4'h0, ax = 4'h1;
   logic [1:0]  pl = 2'h0;
   logic [63:0] serr;
   int          n_fail = 0, check_count = 0, cyc = 0, lat = 0;

   pts_sequencer #(.NOCHK_CYC(20)) dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cfg_pass_decel(1'h1), .cfg_const_acc(ca),
      .prog_restart(rst_p), .blk_valid(vld), .blk_ready(rdy), .blk_kind(kind),
      .blk_axes(ax), .blk_plane(pl), .blk_dir_same(dsame), .gen_done(gdone),
      .mv_start(mvs), .mv_kind(mk), .mv_axes(mva), .mv_plane(mpl), .mv_pass(mvp),
      .mv_overlap_decel(ovd), .mv_const_acc(mca), .mv_trapezoid(mtr), .srv_err(serr));
   pts_servo_model sv_u (.clk(clk), .mv_start(mvs), .gen_len(gl), .settle(st),
      .gen_done(gdone), .srv_err(serr));

   always #2 clk = ~clk;
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // offer one block; m: 0 stop, 1 pass, 2 check-off window, 3 unchecked, 4 const-acc pass
   task automatic mv(input logic [3:0] k, input logic [3:0] a, input logic [1:0] p,
                     input logic d, input int m);
      @(posedge clk);
      vld <= 1'h1;
      kind <= k;
      ax <= a;
      pl <= p;
      dsame <= d;
      do @(negedge clk); while (rdy !== 1'h1);
      @(posedge clk);
      vld <= 1'h0;
      lat = 0;
      if (!k[3]) do begin @(negedge clk); lat++; end while (mvs !== 1'h1 && lat < 400);
      if (!k[3]) chk({22'h0, mk, mva, mpl}, {22'h0, k, a, p});
      if (m == 1) begin
         chk(lat, 1);
         chk({mvp, mtr, ovd}, 32'h7);
      end else if (m == 0) begin
         chk(mvp, 32'h0);
         chk(lat > 16, 32'h1);
      end else if (m == 2) begin
         chk(mvp, 32'h0);
         chk(lat >= 17 && lat <= 25, 32'h1);
      end else if (m == 4) begin
         chk(lat, 9);
         chk({mvp, mtr, ovd, mca}, 32'hd);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge clk);
      apb(1'h0, PTS_OFS_STATUS, 32'h0);   chk(rd & 32'h3, 32'h0);
      apb(1'h0, PTS_OFS_SETTINGS, 32'h0); chk(rd, 32'h1);
      apb(1'h1, PTS_OFS_SETTINGS, 32'h3); chk(perr, 32'h1);
      apb(1'h0, PTS_OFS_SETTINGS, 32'h0); chk(rd, 32'h1);
      apb(1'h0, PTS_OFS_ZONE, 32'h0);     chk(rd, 32'h0000000a);
      apb(1'h1, PTS_OFS_ZONE, 32'h000c);
      apb(1'h0, PTS_OFS_ZONE, 32'h0);     chk(rd, 32'h0000000c);
      apb(1'h0, 8'h0c, 32'h0);            chk(perr, 32'h1);
      $display("test registers done");
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 1);
      mv(PTS_K_CIRCULAR, 4'h3, 2'h0, 1'h0, 1);
      mv(PTS_K_CIRCULAR, 4'h3, 2'h0, 1'h0, 1);
      mv(PTS_K_CIRCULAR, 4'h3, 2'h1, 1'h0, 0);
      mv(PTS_K_TRAVERSE, 4'h3, 2'h0, 1'h0, 0);
      mv(PTS_K_TRAVERSE, 4'h3, 2'h0, 1'h0, 0);
      mv(PTS_K_TRAVERSE, 4'h3, 2'h0, 1'h1, 1);
      mv(PTS_K_TRAVERSE, 4'hc, 2'h0, 1'h1, 0);
      mv(PTS_K_LINEAR, 4'hc, 2'h0, 1'h0, 1);
      mv(PTS_K_CIRCULAR, 4'hc, 2'h0, 1'h0, 1);
      $display("test pass mode done");
      mv(PTS_K_SET_STOP, 4'h0, 2'h0, 1'h0, 3);
      apb(1'h0, PTS_OFS_STATUS, 32'h0);   chk(rd & 32'h3, 32'h1);
      // the last pass move is still settling, so start a fresh one to wait on
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 0);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 0);
      $display("test stop mode done");
      gl <= 8'hc8;
      mv(PTS_K_SET_NOCHK, 4'h0, 2'h0, 1'h0, 3);
      apb(1'h0, PTS_OFS_STATUS, 32'h0);   chk(rd & 32'h3, 32'h2);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 2);
      $display("test check-off mode done");
      gl <= 8'h08;
      @(posedge clk);
      rst_p <= 1'h1;
      @(posedge clk);
      rst_p <= 1'h0;
      apb(1'h0, PTS_OFS_STATUS, 32'h0);   chk(rd & 32'h3, 32'h0);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 1);
      $display("test restart done");
      // settings are only captured after reset, so reset again with const-acc on
      @(posedge clk);
      ca <= 1'h1;
      arst_n <= 1'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge clk);
      apb(1'h0, PTS_OFS_SETTINGS, 32'h0); chk(rd, 32'h3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 3);
      mv(PTS_K_LINEAR, 4'h1, 2'h0, 1'h0, 4);
      mv(PTS_K_LINEAR, 4'h3, 2'h0, 1'h0, 0);
      $display("test constant acceleration done");
      close_out();
   end
endmodule
`default_nettype wire
